// file: hdl/acrb_pkg.sv
`default_nettype none

package acrb_pkg;

  // Bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Page bases
  localparam logic [31:0] CFG_BASE  = 32'h0000_0000;
  localparam logic [31:0] STAT_BASE = 32'h0000_0200;
  localparam int          STAT_WORDS = 32;

  // Configuration word offsets, in table order
  localparam int CFG_REGS = 38;
  localparam logic [15:0] CFG_OFFS [CFG_REGS] = '{
    16'h0000, 16'h0004, 16'h0008, 16'h000C, 16'h0014, 16'h0020, 16'h0024, 16'h002C,
    16'h0030, 16'h0034, 16'h0038, 16'h003C, 16'h0040, 16'h0044, 16'h0048, 16'h004C,
    16'h0050, 16'h0054, 16'h0058, 16'h005C, 16'h0060, 16'h0084, 16'h0088, 16'h0090,
    16'h00A0, 16'h00A4, 16'h00A8, 16'h00AC, 16'h00B0, 16'h00B4, 16'h00B8, 16'h00BC,
    16'h00C0, 16'h00C4, 16'h00C8, 16'h00CC, 16'h1000, 16'h107C};

  // Index of the read-only version word (offset 0x24)
  localparam int VERSION_IDX = 6;

  // Reset value of writable configuration words
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// file: hdl/acrb_if.sv
`timescale 1ns/1ns
`default_nettype none

interface acrb_if;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;

  modport slv (
    input  awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
    output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
  );

  modport mst (
    output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
    input  awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
  );
endinterface

`default_nettype wire

// file: hdl/acrb_slave.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module acrb_slave #(
  parameter logic [31:0] VERSION_ID    = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] DRP_RSVD_MASK = 32'h0000_0000
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        SRESET,
  input  wire logic        CLK_EN,
  acrb_if.slv              AXI,
  output logic      [31:0] CFG_WORDS [acrb_pkg::CFG_REGS],
  input  wire logic [31:0] STAT_WORDS [acrb_pkg::STAT_WORDS]
);

  logic        aw_held_ff;
  logic        w_held_ff;
  logic        bvalid_ff;
  logic        rvalid_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] cfg_ff [acrb_pkg::CFG_REGS];
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        wr_go;
  int          wr_idx;
  int          rd_idx;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;

  // Word index of a configuration offset, or -1
  function automatic int cfg_index(input logic [31:0] a);
    int r;
    r = -1;
    for (int i = 0; i < acrb_pkg::CFG_REGS; i++) begin
      if (a[31:2] == {16'h0000, acrb_pkg::CFG_OFFS[i][15:2]}) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Channel accepts, one write and one read in flight
  // address and data accept
  assign AXI.awready = !aw_held_ff && !bvalid_ff;
  assign AXI.wready  = !w_held_ff && !bvalid_ff;
  assign AXI.arready = !rvalid_ff;
  assign aw_take = AXI.awvalid && AXI.awready;
  assign w_take  = AXI.wvalid && AXI.wready;
  assign ar_take = AXI.arvalid && AXI.arready;
  assign wr_go   = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_idx  = cfg_index(awaddr_ff);
  assign rd_idx  = cfg_index(AXI.araddr);

  // Response outputs
  assign AXI.bvalid = bvalid_ff;
  assign AXI.bresp  = bresp_ff;
  assign AXI.rvalid = rvalid_ff;
  assign AXI.rdata  = rdata_ff;
  assign AXI.rresp  = rresp_ff;

  // Configuration words to the core
  always_comb begin
    for (int i = 0; i < acrb_pkg::CFG_REGS; i++) begin
      CFG_WORDS[i] = cfg_ff[i];
    end
  end

  // Write address capture
  // async and sync resets
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (SRESET) begin
        aw_held_ff <= 1'b0;
      end else if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= AXI.awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  // Write data capture, either order with address
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (CLK_EN) begin
      if (SRESET) begin
        w_held_ff <= 1'b0;
      end else if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= AXI.wdata;
        wstrb_ff  <= AXI.wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response
  // hold until bready
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= acrb_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      if (SRESET) begin
        bvalid_ff <= 1'b0;
        bresp_ff  <= acrb_pkg::RESP_OKAY;
      end else if (wr_go) begin
        bvalid_ff <= 1'b1;
        if (wr_idx >= 0 && wr_idx != acrb_pkg::VERSION_IDX) begin
          bresp_ff <= acrb_pkg::RESP_OKAY;
        end else begin
          bresp_ff <= acrb_pkg::RESP_SLVERR;
        end
      end else if (bvalid_ff && AXI.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Configuration storage
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < acrb_pkg::CFG_REGS; i++) begin
        cfg_ff[i] <= (i == acrb_pkg::VERSION_IDX) ? VERSION_ID : acrb_pkg::CFG_RESET;
      end
    end else if (CLK_EN) begin
      if (SRESET) begin
        for (int i = 0; i < acrb_pkg::CFG_REGS; i++) begin
          cfg_ff[i] <= (i == acrb_pkg::VERSION_IDX) ? VERSION_ID : acrb_pkg::CFG_RESET;
        end
      end else if (wr_go && wr_idx >= 0 && wr_idx != acrb_pkg::VERSION_IDX) begin
        for (int b = 0; b < acrb_pkg::STRB_W; b++) begin
          if (wstrb_ff[b]) begin
            cfg_ff[wr_idx][8*b +: 8] <= wdata_ff[8*b +: 8] & ~DRP_RSVD_MASK[8*b +: 8];
          end
        end
      end
    end
  end

  // Read decode
  // two pages
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = acrb_pkg::RESP_OKAY;
    if (rd_idx >= 0) begin
      nxt_rdata = cfg_ff[rd_idx];
    end else if (AXI.araddr[31:7] == acrb_pkg::STAT_BASE[31:7]) begin
      nxt_rdata = STAT_WORDS[AXI.araddr[6:2]];
    end else begin
      nxt_rresp = acrb_pkg::RESP_SLVERR;
    end
  end

  // Read response
  // data and code held together
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= acrb_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      if (SRESET) begin
        rvalid_ff <= 1'b0;
      end else if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= nxt_rresp;
      end else if (rvalid_ff && AXI.rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: hdl/acrb_master.sv
`timescale 1ns/1ns
`default_nettype none

module acrb_master (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  acrb_if.mst              AXI,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic        CMD_WRITE,
  input  wire logic [31:0] CMD_ADDR,
  input  wire logic [31:0] CMD_WDATA,
  input  wire logic [3:0]  CMD_WSTRB,
  output logic             RSP_VALID,
  output logic      [31:0] RSP_RDATA,
  output logic             RSP_ERR
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WRITE = 4'h2,
    ST_READ  = 4'h4,
    ST_ACK   = 4'h8
  } acrb_state_type;

  acrb_state_type state_ff;
  acrb_state_type nxt_state;
  logic           awvalid_ff;
  logic           wvalid_ff;
  logic           arvalid_ff;
  logic [31:0]    awaddr_ff;
  logic [31:0]    wdata_ff;
  logic [3:0]     wstrb_ff;
  logic [31:0]    araddr_ff;
  logic [31:0]    rdata_ff;
  logic           err_ff;

  assign CMD_READY   = (state_ff == ST_IDLE);
  assign RSP_VALID   = (state_ff == ST_ACK);
  assign RSP_RDATA   = rdata_ff;
  assign RSP_ERR     = err_ff;
  assign AXI.awvalid = awvalid_ff;
  assign AXI.awaddr  = awaddr_ff;
  assign AXI.wvalid  = wvalid_ff;
  assign AXI.wdata   = wdata_ff;
  assign AXI.wstrb   = wstrb_ff;
  assign AXI.arvalid = arvalid_ff;
  assign AXI.araddr  = araddr_ff;
  assign AXI.bready  = (state_ff == ST_WRITE);
  assign AXI.rready  = (state_ff == ST_READ);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (CMD_VALID) begin
          nxt_state = CMD_WRITE ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        if (AXI.bvalid) begin
          nxt_state = ST_ACK;
        end
      end
      ST_READ: begin
        if (AXI.rvalid) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_IDLE;
    end else if (CLK_EN) begin
      state_ff <= nxt_state;
    end
  end

  // Request channels, each released when taken
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      awvalid_ff <= 1'b0;
      wvalid_ff  <= 1'b0;
      arvalid_ff <= 1'b0;
      awaddr_ff  <= 32'h0000_0000;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      araddr_ff  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (state_ff == ST_IDLE && CMD_VALID) begin
        if (CMD_WRITE) begin
          awvalid_ff <= 1'b1;
          wvalid_ff  <= 1'b1;
          awaddr_ff  <= CMD_ADDR;
          wdata_ff   <= CMD_WDATA;
          wstrb_ff   <= CMD_WSTRB;
        end else begin
          arvalid_ff <= 1'b1;
          araddr_ff  <= CMD_ADDR;
        end
      end else begin
        if (awvalid_ff && AXI.awready) begin
          awvalid_ff <= 1'b0;
        end
        if (wvalid_ff && AXI.wready) begin
          wvalid_ff <= 1'b0;
        end
        if (arvalid_ff && AXI.arready) begin
          arvalid_ff <= 1'b0;
        end
      end
    end
  end

  // Captured answer
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end else if (CLK_EN) begin
      if (state_ff == ST_WRITE && AXI.bvalid) begin
        err_ff <= (AXI.bresp != acrb_pkg::RESP_OKAY);
      end else if (state_ff == ST_READ && AXI.rvalid) begin
        rdata_ff <= AXI.rdata;
        err_ff   <= (AXI.rresp != acrb_pkg::RESP_OKAY);
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/acrb_checker.sv
`timescale 1ns/1ns
`default_nettype none

module acrb_checker (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // Answer timing and blocking
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> !awready && !wready ##[0:1] bvalid)
    else $error("write not answered");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered");
  a_bresp_free: assert property (
    bvalid && bready |=> !bvalid && awready && wready)
    else $error("write response not released");
  a_rresp_free: assert property (
    rvalid && rready |=> !rvalid && arready)
    else $error("read response not released");
  a_ar_idle: assert property (
    !rvalid |-> arready)
    else $error("read address refused while idle");
  // Response codes and causes
  a_bresp_code: assert property (
    bvalid |-> bresp == acrb_pkg::RESP_OKAY || bresp == acrb_pkg::RESP_SLVERR)
    else $error("bad write code");
  a_rresp_code: assert property (
    rvalid && rresp != acrb_pkg::RESP_OKAY |-> rresp == acrb_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("bad read code");
  a_b_cause: assert property (
    $rose(bvalid) |-> $past(awvalid && wvalid) || $past(awvalid && wvalid, 2))
    else $error("write response without write");
  a_r_cause: assert property (
    $rose(rvalid) |-> $past(arvalid && arready))
    else $error("read response without read");
endmodule

`default_nettype wire

// file: tb/axi_lite_config_register_bank_bench.sv
`timescale 1ns/1ns
`default_nettype none

module axi_lite_config_register_bank_bench;
  localparam logic [31:0] VER = 32'h0000_5A01; // Arbitrary value
  localparam logic [31:0] MSK = 32'hF000_000F; // Port-owned bits under test
  logic        sys_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        sreset = 1'h0;
  logic        clk_en = 1'h1;
  logic        c_vld = 1'h0;
  logic        c_wr = 1'h0;
  logic [31:0] c_adr = 32'h0;
  logic [31:0] c_dat = 32'h0;
  logic [3:0]  c_stb = 4'h0;
  logic        c_rdy;
  logic        r_vld;
  logic [31:0] r_dat;
  logic        r_err;
  logic [31:0] stat [acrb_pkg::STAT_WORDS];
  logic [31:0] cfg [acrb_pkg::CFG_REGS];
  logic [1:0]  resp;
  logic [3:0]  seen_stb;
  int          error_cnt = 0;
  int          checks_done = 0;
  acrb_if      bus ();

  // Clock, 4 ns period
  always #2 sys_clk = ~sys_clk;

  acrb_slave #(.VERSION_ID(VER), .DRP_RSVD_MASK(MSK)) u_acrb_slave (.SYS_CLK(sys_clk),
    .RESET_N(reset_n), .SRESET(sreset), .CLK_EN(clk_en), .AXI(bus), .CFG_WORDS(cfg),
    .STAT_WORDS(stat));
  acrb_master u_acrb_master (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
    .AXI(bus), .CMD_VALID(c_vld), .CMD_READY(c_rdy), .CMD_WRITE(c_wr), .CMD_ADDR(c_adr),
    .CMD_WDATA(c_dat), .CMD_WSTRB(c_stb), .RSP_VALID(r_vld), .RSP_RDATA(r_dat),
    .RSP_ERR(r_err));
  acrb_checker u_acrb_checker (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .awvalid(bus.awvalid), .awready(bus.awready), .wvalid(bus.wvalid), .wready(bus.wready),
    .bresp(bus.bresp), .bvalid(bus.bvalid), .bready(bus.bready), .arvalid(bus.arvalid),
    .arready(bus.arready), .rdata(bus.rdata), .rresp(bus.rresp), .rvalid(bus.rvalid),
    .rready(bus.rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One command through the master, wire codes watched
  task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s,
                      input logic [31:0] exp, input logic err);
    resp = 2'h1;
    seen_stb = 4'h0;
    @(negedge sys_clk);
    check(c_rdy, 1'h1);
    @(posedge sys_clk);
    c_vld <= 1'h1;
    c_wr <= w;
    c_adr <= a;
    c_dat <= d;
    c_stb <= s;
    @(posedge sys_clk);
    c_vld <= 1'h0;
    for (int n = 0; n < 20 && r_vld !== 1'h1; n++) begin
      @(negedge sys_clk);
      if (bus.wvalid === 1'h1) seen_stb = bus.wstrb;
      if (bus.bvalid === 1'h1) resp = bus.bresp;
      if (bus.rvalid === 1'h1) resp = bus.rresp;
    end
    check(r_vld, 1'h1);
    check(r_err, err);
    check(resp, err ? acrb_pkg::RESP_SLVERR : acrb_pkg::RESP_OKAY);
    if (w) check(seen_stb, s);
    else check(r_dat, exp);
  endtask

  // Every configuration word: reset value, write, read back
  task automatic t_map();
    logic [31:0] a;
    logic [31:0] v;
    logic        ro;
    for (int i = 0; i < acrb_pkg::CFG_REGS; i++) begin
      a = 32'(acrb_pkg::CFG_OFFS[i]);
      ro = (i == acrb_pkg::VERSION_IDX);
      v = ro ? VER : acrb_pkg::CFG_RESET;
      xfer(1'h0, a, 32'h0, 4'h0, v, 1'h0);
      xfer(1'h1, a, ~a, 4'hF, 32'h0, ro);
      v = ro ? VER : (~a & ~MSK);
      xfer(1'h0, a, 32'h0, 4'h0, v, 1'h0);
      check(cfg[i], v);
    end
  endtask

  // Partial strobes, low address bits ignored
  task automatic t_strobe();
    xfer(1'h1, 32'h0000_00CC, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'h0);
    xfer(1'h1, 32'h0000_00CC, 32'h1122_3344, 4'h5, 32'h0, 1'h0);
    xfer(1'h0, 32'h0000_00CF, 32'h0, 4'h0, 32'hFF22_FF44 & ~MSK, 1'h0);
  endtask

  // Holes and status page
  task automatic t_holes();
    logic [31:0] h [8] = '{32'h10, 32'h18, 32'h28, 32'h64, 32'h8C, 32'h94, 32'h1FC, 32'h1004};
    for (int i = 0; i < 8; i++) begin
      xfer(1'h1, h[i], 32'hFFFF_FFFF, 4'hF, 32'h0, 1'h1);
      xfer(1'h0, h[i], 32'h0, 4'h0, 32'h0, 1'h1);
    end
    check(cfg[35], 32'hFF22_FF44 & ~MSK);
    xfer(1'h0, 32'h0000_0200, 32'h0, 4'h0, stat[0], 1'h0);
    xfer(1'h0, 32'h0000_027C, 32'h0, 4'h0, stat[31], 1'h0);
    xfer(1'h1, 32'h0000_0204, 32'h0, 4'hF, 32'h0, 1'h1);
  endtask

  // Synchronous reset while idle
  task automatic t_sreset();
    @(posedge sys_clk);
    sreset <= 1'h1;
    @(posedge sys_clk);
    sreset <= 1'h0;
    @(negedge sys_clk);
    check(cfg[35], acrb_pkg::CFG_RESET);
    check(cfg[6], VER);
    xfer(1'h0, 32'h0000_00CC, 32'h0, 4'h0, acrb_pkg::CFG_RESET, 1'h0);
  endtask

  // Clock enable low: synchronous reset ignored, words kept
  task automatic t_freeze();
    xfer(1'h1, 32'h0000_00CC, 32'h1234_5678, 4'hF, 32'h0, 1'h0);
    @(posedge sys_clk);
    clk_en <= 1'h0;
    sreset <= 1'h1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    clk_en <= 1'h1;
    sreset <= 1'h0;
    @(negedge sys_clk);
    check(cfg[35], 32'h1234_5678 & ~MSK);
    xfer(1'h0, 32'h0000_00CC, 32'h0, 4'h0, 32'h1234_5678 & ~MSK, 1'h0);
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end

  // Main sequence
  initial begin
    for (int i = 0; i < acrb_pkg::STAT_WORDS; i++) stat[i] <= {24'hA5A5A5, 8'(i)};
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'h1;
    t_map();
    t_strobe();
    t_holes();
    t_sreset();
    t_freeze();
    stop_test();
  end
endmodule

`default_nettype wire
